// File: rtl/psq_core.sv
// Program sequencer: phases, fetch pipeline, return stack, table reads, data memory
// Notes on behaviour
// - Four clock phases make one instruction cycle.
// - Fetch overlaps execute; control transfers insert one dummy cycle.
// - Each fetch advances the program counter by one.
// - A true skip discards the fetched word; execution resumes at counter plus two.
// - Writing the counter low byte jumps within the current page.
// - Reset clears the program counter to zero.
// - Acknowledged interrupts load vector 004, 008 or 00C.
// - Program memory is 6144 sixteen-bit words on a 13-bit address.
// - Option off: table page comes from the program counter high bits.
// - Option on: table page comes from the table high pointer.
// - Last-page table read forces the final page.
// - Table low byte goes to data memory, high byte to result register.
// - Every table read takes two instruction cycles.
// - Eight-level hidden return stack pushed on call or acknowledge.
// - Full stack withholds interrupt acknowledge until a return.
// - Call on a full stack drops the oldest entry.
// - Reset leaves the stack empty.
// - 224 bytes of general data memory with bit and indirect access.
// - Only the program counter is pushed, never the status.
`timescale 1ns/1ps
`include "psq_regs.svh"

module psq_core
    import psq_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_ce,
    input  wire psq_ctl_s    i_ctl,
    input  wire psq_irq_s    i_irq,
    input  wire logic        i_table_pointer_high_en,
    input  wire logic [15:0] i_rom_data,
    input  wire logic [7:0]  i_rd_addr,
    output logic      [1:0]  o_phase,
    output logic      [12:0] o_rom_addr,
    output logic      [15:0] o_ir,
    output logic             o_ir_dummy,
    output logic             o_int_ack,
    output logic      [3:0]  o_stack_depth,
    output logic      [7:0]  o_rd_data
);
    logic [1:0]  phase_reg, phase_next;
    logic [12:0] fa_reg, fa_next;
    logic [12:0] irpc_reg, irpc_next;
    logic [12:0] ret_reg, ret_next;
    logic [15:0] ir_reg, ir_next;
    logic        dummy_reg, dummy_next;
    logic        pend_reg, pend_next;
    logic        ack_reg, ack_next;
    logic [7:0]  dst_reg, dst_next;
    logic [12:0] stk_reg [`PSQ_STK_D];
    logic [12:0] stk_next [`PSQ_STK_D];
    logic [2:0]  sp_reg, sp_next;
    logic [3:0]  cnt_reg, cnt_next;
    logic [7:0]  mp0_reg, mp0_next;
    logic [7:0]  mp1_reg, mp1_next;
    logic [7:0]  table_pointer_low_reg, table_pointer_low_next;
    logic [7:0]  table_pointer_high_reg, table_pointer_high_next;
    logic [7:0]  table_high_result_reg, table_high_result_next;
    logic [7:0]  rd_reg, rd_next;
    logic [7:0]  ram_reg [`PSQ_RAM_N];
    logic [7:0]  ram_next [`PSQ_RAM_N];
    logic        bnd, plain, take_int;
    logic [12:0] vec;
    logic [2:0]  sp_dec;
    psq_wm_e     w_mode;
    logic [7:0]  w_addr, w_val, w_res, w_cur, w_mask;
    logic [2:0]  w_idx;

    // Slots 00 and 02 read through the pointers; a pointer aimed at them reads zero
    function automatic logic [7:0] psq_res(input logic [7:0] a);
        if (a == `PSQ_A_IND0) return mp0_reg;
        if (a == `PSQ_A_IND1) return mp1_reg;
        return a;
    endfunction : psq_res

    function automatic logic [7:0] psq_rd(input logic [7:0] a);
        case (a)
            `PSQ_A_MP0:  return mp0_reg;
            `PSQ_A_MP1:  return mp1_reg;
            `PSQ_A_PCL:  return fa_reg[7:0];
            `PSQ_A_TABLE_POINTER_LOW: return table_pointer_low_reg;
            `PSQ_A_TABLE_HIGH_RESULT: return table_high_result_reg;
            `PSQ_A_TABLE_POINTER_HIGH: return table_pointer_high_reg;
            default:     return (a >= `PSQ_A_RAM) ? ram_reg[a - `PSQ_A_RAM] : `PSQ_RST8;
        endcase
    endfunction : psq_rd

    assign bnd    = i_ce && phase_reg == `PSQ_PH_LAST;
    assign sp_dec = sp_reg - 3'd1;
    // Interrupts wait out transfers so a return address is never ambiguous
    // Process form so pointer changes seen inside the resolver retrigger it
    always_comb begin
        plain = i_ctl.op == OP_SEQ
              && !(i_ctl.wm != WM_NONE && psq_res(i_ctl.addr) == `PSQ_A_PCL);
    end
    assign take_int = bnd && !pend_reg && i_irq.req
                    && cnt_reg != `PSQ_STK_N && (dummy_reg || plain);

    always_comb begin
        case (i_irq.src)
            2'd0:    vec = `PSQ_V_USB;
            2'd1:    vec = `PSQ_V_T0;
            2'd2:    vec = `PSQ_V_T1;
            default: vec = `PSQ_V_USB;
        endcase
    end

    always_comb begin
        phase_next = phase_reg;
        fa_next    = fa_reg;
        irpc_next  = irpc_reg;
        ret_next   = ret_reg;
        ir_next    = ir_reg;
        dummy_next = dummy_reg;
        pend_next  = pend_reg;
        ack_next   = ack_reg;
        dst_next   = dst_reg;
        stk_next   = stk_reg;
        sp_next    = sp_reg;
        cnt_next   = cnt_reg;
        mp0_next   = mp0_reg;
        mp1_next   = mp1_reg;
        table_pointer_low_next  = table_pointer_low_reg;
        table_pointer_high_next  = table_pointer_high_reg;
        table_high_result_next  = table_high_result_reg;
        rd_next    = rd_reg;
        ram_next   = ram_reg;
        w_mode     = WM_NONE;
        w_addr     = i_ctl.addr;
        w_val      = i_ctl.data;
        w_idx      = i_ctl.bit_idx;
        if (i_ce) begin
            phase_next = phase_reg + 2'd1;
            rd_next    = psq_rd(psq_res(i_rd_addr));
        end
        if (bnd) begin
            ack_next = 1'b0;
            if (pend_reg) begin
                // Second table cycle: fetched word is data, the held word runs next
                table_high_result_next  = i_rom_data[15:8];
                w_mode     = WM_BYTE;
                w_addr     = dst_reg;
                w_val      = i_rom_data[7:0];
                fa_next    = ret_reg;
                pend_next  = 1'b0;
                dummy_next = 1'b0;
            end else begin
                ir_next    = i_rom_data;
                irpc_next  = fa_reg;
                dummy_next = 1'b0;
                fa_next    = fa_reg + 13'd1;
                if (!dummy_reg) begin
                    w_mode = i_ctl.wm;
                    case (i_ctl.op)
                        OP_SKIP: begin
                            if (i_ctl.skip_true) dummy_next = 1'b1;
                        end
                        OP_JUMP: begin
                            fa_next    = i_ctl.target;
                            dummy_next = 1'b1;
                        end
                        OP_CALL: begin
                            // Circular store: on overflow the oldest slot is overwritten
                            stk_next[sp_reg] = fa_reg;
                            sp_next    = sp_reg + 3'd1;
                            if (cnt_reg != `PSQ_STK_N) cnt_next = cnt_reg + 4'd1;
                            fa_next    = i_ctl.target;
                            dummy_next = 1'b1;
                        end
                        OP_RET, OP_INTERRUPT_RETURN: begin
                            fa_next    = stk_reg[sp_dec];
                            sp_next    = sp_dec;
                            if (cnt_reg != 4'h0) cnt_next = cnt_reg - 4'd1;
                            dummy_next = 1'b1;
                        end
                        OP_TBL_CUR, OP_TBL_LAST: begin
                            if (i_ctl.op == OP_TBL_LAST)
                                fa_next = {`PSQ_PG_LAST, table_pointer_low_reg};
                            else if (i_table_pointer_high_en)
                                fa_next = {table_pointer_high_reg[4:0], table_pointer_low_reg};
                            else
                                fa_next = {fa_reg[12:8], table_pointer_low_reg};
                            ret_next   = fa_reg + 13'd1;
                            dst_next   = i_ctl.addr;
                            pend_next  = 1'b1;
                            dummy_next = 1'b1;
                            w_mode     = WM_NONE;
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
        w_cur  = psq_rd(psq_res(w_addr));
        w_mask = 8'h01 << w_idx;
        case (w_mode)
            WM_BSET: w_res = w_cur | w_mask;
            WM_BCLR: w_res = w_cur & ~w_mask;
            default: w_res = w_val;
        endcase
        if (w_mode != WM_NONE) begin
            case (psq_res(w_addr))
                `PSQ_A_MP0:  mp0_next = w_res;
                `PSQ_A_MP1:  mp1_next = w_res;
                `PSQ_A_TABLE_POINTER_LOW: table_pointer_low_next = w_res;
                `PSQ_A_TABLE_POINTER_HIGH: table_pointer_high_next = w_res;
                `PSQ_A_PCL: begin
                    fa_next    = {irpc_reg[12:8], w_res};
                    dummy_next = 1'b1;
                end
                default: begin
                    if (psq_res(w_addr) >= `PSQ_A_RAM)
                        ram_next[psq_res(w_addr) - `PSQ_A_RAM] = w_res;
                end
            endcase
        end
        if (take_int) begin
            // Word just fetched is dropped and refetched after the service routine
            stk_next[sp_reg] = fa_reg;
            sp_next    = sp_reg + 3'd1;
            cnt_next   = cnt_reg + 4'd1;
            fa_next    = vec;
            dummy_next = 1'b1;
            ack_next   = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            phase_reg <= 2'h0;
            fa_reg    <= `PSQ_V_RST;
            irpc_reg  <= `PSQ_V_RST;
            ret_reg   <= `PSQ_V_RST;
            ir_reg    <= 16'h0000;
            dummy_reg <= 1'b1;
            pend_reg  <= 1'b0;
            ack_reg   <= 1'b0;
            dst_reg   <= `PSQ_RST8;
            sp_reg    <= 3'h0;
            cnt_reg   <= 4'h0;
            mp0_reg   <= `PSQ_RST8;
            mp1_reg   <= `PSQ_RST8;
            table_pointer_low_reg  <= `PSQ_RST8;
            table_pointer_high_reg  <= `PSQ_RST8;
            table_high_result_reg  <= `PSQ_RST8;
            rd_reg    <= `PSQ_RST8;
            for (int k = 0; k < `PSQ_STK_D; k++) stk_reg[k] <= 13'h0000;
            for (int k = 0; k < `PSQ_RAM_N; k++) ram_reg[k] <= `PSQ_RST8;
        end else begin
            phase_reg <= phase_next;
            fa_reg    <= fa_next;
            irpc_reg  <= irpc_next;
            ret_reg   <= ret_next;
            ir_reg    <= ir_next;
            dummy_reg <= dummy_next;
            pend_reg  <= pend_next;
            ack_reg   <= ack_next;
            dst_reg   <= dst_next;
            stk_reg   <= stk_next;
            sp_reg    <= sp_next;
            cnt_reg   <= cnt_next;
            mp0_reg   <= mp0_next;
            mp1_reg   <= mp1_next;
            table_pointer_low_reg  <= table_pointer_low_next;
            table_pointer_high_reg  <= table_pointer_high_next;
            table_high_result_reg  <= table_high_result_next;
            rd_reg    <= rd_next;
            ram_reg   <= ram_next;
        end
    end

    assign o_phase       = phase_reg;
    assign o_rom_addr    = fa_reg;
    assign o_ir          = ir_reg;
    assign o_ir_dummy    = dummy_reg;
    assign o_int_ack     = ack_reg;
    assign o_stack_depth = cnt_reg;
    assign o_rd_data     = rd_reg;

    phase_wrap_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        bnd |=> phase_reg == 2'h0 ##0 (!i_ce || phase_reg == 2'h0) ##1 phase_reg != 2'h3)
        else $error("phase count did not wrap after four");
    pc_step_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        bnd && !pend_reg && !dummy_reg && i_ctl.op == OP_SEQ && i_ctl.wm == WM_NONE
        && !take_int |=> fa_reg == $past(fa_reg) + 13'd1 && !o_ir_dummy)
        else $error("fetch address did not advance by one");
    jump_dummy_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        bnd && !pend_reg && !dummy_reg && i_ctl.op == OP_JUMP
        |=> o_ir_dummy && fa_reg == $past(i_ctl.target))
        else $error("jump without dummy slot or wrong target");
    skip_slot_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        bnd && !pend_reg && !dummy_reg && i_ctl.op == OP_SKIP && i_ctl.skip_true
        && i_ctl.wm == WM_NONE |=> o_ir_dummy && fa_reg == $past(fa_reg) + 13'd1)
        else $error("true skip did not discard the fetched word");
    pcl_jump_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        bnd && !pend_reg && !dummy_reg && i_ctl.op == OP_SEQ && i_ctl.wm == WM_BYTE
        && psq_res(i_ctl.addr) == `PSQ_A_PCL
        |=> fa_reg == {$past(irpc_reg[12:8]), $past(i_ctl.data)} && o_ir_dummy)
        else $error("low byte write did not stay in page");
    timer_vec_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        take_int && i_irq.src == 2'd1 |=> o_int_ack && fa_reg == `PSQ_V_T0)
        else $error("timer 0 vector not loaded");
    full_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        bnd && cnt_reg == `PSQ_STK_N |=> !o_int_ack && cnt_reg <= `PSQ_STK_N)
        else $error("acknowledge given on full stack");
    tbl_last_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        bnd && !pend_reg && !dummy_reg && i_ctl.op == OP_TBL_LAST
        |=> pend_reg && fa_reg == {`PSQ_PG_LAST, $past(table_pointer_low_reg)})
        else $error("last page table address wrong");
    tbl_end_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        bnd && pend_reg |=> !pend_reg && !o_ir_dummy && table_high_result_reg == $past(i_rom_data[15:8]))
        else $error("table read did not end in its second cycle");
    stack_push_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        bnd && !pend_reg && !dummy_reg && i_ctl.op == OP_CALL && cnt_reg < `PSQ_STK_N
        |=> cnt_reg == $past(cnt_reg) + 4'd1 && sp_reg == $past(sp_reg) + 3'd1)
        else $error("call did not push");
    stack_ovf_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        bnd && !pend_reg && !dummy_reg && i_ctl.op == OP_CALL && cnt_reg == `PSQ_STK_N
        |=> cnt_reg == `PSQ_STK_N && stk_reg[$past(sp_reg)] == $past(fa_reg))
        else $error("overflowing call mishandled");
endmodule : psq_core

// File: rtl/psq_regs.svh
// Offsets, vectors, reset values and counts of the program sequencer
`ifndef PSQ_REGS_SVH
`define PSQ_REGS_SVH
`define PSQ_A_IND0   8'h00
`define PSQ_A_MP0    8'h01
`define PSQ_A_IND1   8'h02
`define PSQ_A_MP1    8'h03
`define PSQ_A_PCL    8'h06
`define PSQ_A_TABLE_POINTER_LOW   8'h07
`define PSQ_A_TABLE_HIGH_RESULT   8'h08
`define PSQ_A_TABLE_POINTER_HIGH   8'h1f
`define PSQ_A_RAM    8'h20
`define PSQ_RAM_N    224
`define PSQ_STK_D    8
`define PSQ_STK_N    4'h8
`define PSQ_V_RST    13'h0000
`define PSQ_V_USB    13'h0004
`define PSQ_V_T0     13'h0008
`define PSQ_V_T1     13'h000c
`define PSQ_PG_LAST  5'h17
`define PSQ_PH_LAST  2'h3
`define PSQ_RST8     8'h00
`endif

// File: rtl/psq_pkg.sv
// Types shared by the program sequencer
package psq_pkg;
    typedef enum logic [2:0] {
        OP_SEQ, OP_SKIP, OP_JUMP, OP_CALL, OP_RET, OP_INTERRUPT_RETURN, OP_TBL_CUR, OP_TBL_LAST
    } psq_op_e;
    typedef enum logic [1:0] {WM_NONE, WM_BYTE, WM_BSET, WM_BCLR} psq_wm_e;
    typedef struct packed {
        psq_op_e     op;
        logic        skip_true;
        logic [12:0] target;
        psq_wm_e     wm;
        logic [7:0]  addr;
        logic [7:0]  data;
        logic [2:0]  bit_idx;
    } psq_ctl_s;
    typedef struct packed {
        logic       req;
        logic [1:0] src;
    } psq_irq_s;
endpackage : psq_pkg

// File: bench/psq_rom_model.sv
// Program ROM model answering the sequencer fetch port
`timescale 1ns/1ps
module psq_rom_model
    import psq_pkg::*;
(
    input  wire logic [12:0] i_addr,
    output logic      [15:0] o_data
);
    localparam int WORDS = 6144;
    // Word carries its own address so a misrouted fetch shows at once
    always_comb begin
        if (i_addr < 13'(WORDS)) begin
            o_data = {3'h5, i_addr};
        end else begin
            // No word here; inverted pattern so it never passes for data
            o_data = ~{3'h5, i_addr};
        end
    end
endmodule : psq_rom_model

// File: bench/program_sequencer_stack_table_read_bench.sv
// Self-checking bench for the program sequencer
`timescale 1ns/1ps
module program_sequencer_stack_table_read_bench
    import psq_pkg::*;
;
    logic        i_clk;
    logic        i_sys_rst;
    logic        i_ce;
    psq_ctl_s    i_ctl;
    psq_irq_s    i_irq;
    logic        i_table_pointer_high_en;
    logic [15:0] rom_data;
    logic [7:0]  i_rd_addr;
    logic [1:0]  o_phase;
    logic [12:0] o_rom_addr;
    logic [15:0] o_ir;
    logic        o_ir_dummy;
    logic        o_int_ack;
    logic [3:0]  o_stack_depth;
    logic [7:0]  o_rd_data;
    logic [12:0] pc;
    logic [12:0] pushed [0:8];
    logic [4:0]  pg;
    int          error_cnt = 0;
    int          checks = 0;
    int          cyc = 0;

    psq_core uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_ctl(i_ctl),
        .i_irq(i_irq), .i_table_pointer_high_en(i_table_pointer_high_en), .i_rom_data(rom_data), .i_rd_addr(i_rd_addr),
        .o_phase(o_phase), .o_rom_addr(o_rom_addr), .o_ir(o_ir), .o_ir_dummy(o_ir_dummy),
        .o_int_ack(o_int_ack), .o_stack_depth(o_stack_depth), .o_rd_data(o_rd_data));
    psq_rom_model rom (.i_addr(o_rom_addr), .o_data(rom_data));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    function automatic logic [15:0] romw(input logic [12:0] a);
        return {3'h5, a};
    endfunction : romw

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    // Whole run needs a few hundred cycles; a hang stops here
    always @(posedge i_clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            error_cnt = error_cnt + 1;
            report_and_stop();
        end
    end

    // One instruction: drive at an edge, return once its boundary has landed
    task automatic drv(input psq_ctl_s c, input psq_irq_s q);
        @(posedge i_clk);
        i_ctl <= c;
        i_irq <= q;
        do @(negedge i_clk); while (o_phase !== 2'h3);
        @(negedge i_clk);
    endtask : drv

    task automatic go(input psq_op_e op, input logic [12:0] t = 13'h0000,
                      input logic irq = 1'b0, input logic [1:0] src = 2'h0);
        drv('{op, op == OP_SKIP, t, WM_NONE, 8'h50, 8'h00, 3'h0}, '{irq, src});
    endtask : go

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input psq_wm_e wm = WM_BYTE, input logic [2:0] b = 3'h0);
        drv('{OP_SEQ, 1'b0, 13'h0000, wm, a, d, b}, '{1'b0, 2'h0});
    endtask : wr

    // Neutral control so the boundaries passed meanwhile do nothing
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge i_clk);
        i_ctl <= '{OP_SEQ, 1'b0, 13'h0000, WM_NONE, 8'h00, 8'h00, 3'h0};
        i_rd_addr <= a;
        @(posedge i_clk);
        @(negedge i_clk);
        chk(what, {8'h00, o_rd_data}, {8'h00, exp});
    endtask : rd

    initial begin
        i_sys_rst = 1'b1;
        i_ce = 1'b1;
        i_ctl = '0;
        i_irq = '0;
        i_table_pointer_high_en = 1'b0;
        i_rd_addr = 8'h00;
        repeat (8) @(posedge i_clk);
        chk("reset pc", 16'(o_rom_addr), 16'h0000);
        chk("reset depth", 16'(o_stack_depth), 16'h0000);
        i_sys_rst <= 1'b0;
        go(OP_SEQ);
        chk("first pc", 16'(o_rom_addr), 16'h0001);
        chk("first word", o_ir, romw(13'h0000));
        go(OP_SEQ);
        chk("seq dummy", 16'(o_ir_dummy), 16'h0000);
        chk("seq pc", 16'(o_rom_addr), 16'h0002);
        for (int k = 1; k <= 4; k++) begin
            @(negedge i_clk);
            chk("phase", 16'(o_phase), 16'(k % 4));
        end
        @(posedge i_clk);
        i_ce <= 1'b0;
        repeat (3) @(negedge i_clk);
        chk("frozen phase", 16'(o_phase), 16'h0001);
        @(posedge i_clk);
        i_ce <= 1'b1;
        go(OP_JUMP, 13'h01ff);
        chk("jump pc", 16'(o_rom_addr), 16'h01ff);
        chk("jump dummy", 16'(o_ir_dummy), 16'h0001);
        go(OP_SEQ);
        chk("jump word", o_ir, romw(13'h01ff));
        // Executing 1ff while fetching 200: page must come from 1ff
        wr(8'h06, 8'h40);
        chk("short jump", 16'(o_rom_addr), 16'h0140);
        go(OP_SEQ);
        go(OP_SKIP);
        chk("skip dummy", 16'(o_ir_dummy), 16'h0001);
        go(OP_SEQ);
        chk("skip word", o_ir, romw(13'h0142));
        wr(8'h40, 8'h5a);
        wr(8'h40, 8'h00, WM_BSET, 3'h0);
        wr(8'h40, 8'h00, WM_BCLR, 3'h6);
        wr(8'h01, 8'h40);
        wr(8'h08, 8'hff);
        rd(8'h40, 8'h1b, "ram bits");
        rd(8'h00, 8'h1b, "indirect");
        rd(8'h08, 8'h00, "result ro");
        go(OP_JUMP, 13'h0080);
        go(OP_SEQ);
        for (int s = 0; s < 3; s++) begin
            pc = o_rom_addr;
            go(OP_SEQ, 13'h0000, 1'b1, 2'(s));
            chk("vector", 16'(o_rom_addr), 16'(4 * (s + 1)));
            chk("ack", 16'(o_int_ack), 16'h0001);
            chk("irq depth", 16'(o_stack_depth), 16'h0001);
            go(OP_SEQ);
            chk("ack drop", 16'(o_int_ack), 16'h0000);
            go(OP_INTERRUPT_RETURN);
            chk("interrupt_return pc", 16'(o_rom_addr), 16'(pc));
            go(OP_SEQ);
        end
        for (int k = 0; k < 9; k++) begin
            pushed[k] = o_rom_addr;
            go(OP_CALL, 13'h0300 + 13'(k * 16));
            go(OP_SEQ);
            chk("call depth", 16'(o_stack_depth), 16'(k < 8 ? k + 1 : 8));
        end
        go(OP_SEQ, 13'h0000, 1'b1, 2'h0);
        chk("held ack", 16'(o_int_ack), 16'h0000);
        go(OP_RET);
        chk("ret pc", 16'(o_rom_addr), 16'(pushed[8]));
        go(OP_SEQ);
        pc = o_rom_addr;
        go(OP_SEQ, 13'h0000, 1'b1, 2'h0);
        chk("late ack", 16'(o_int_ack), 16'h0001);
        chk("late vector", 16'(o_rom_addr), 16'h0004);
        go(OP_SEQ);
        go(OP_INTERRUPT_RETURN);
        chk("late interrupt_return", 16'(o_rom_addr), 16'(pc));
        go(OP_SEQ);
        for (int k = 7; k >= 1; k--) begin
            go(k == 1 ? OP_INTERRUPT_RETURN : OP_RET);
            chk("pop", 16'(o_rom_addr), 16'(pushed[k]));
            go(OP_SEQ);
        end
        chk("empty", 16'(o_stack_depth), 16'h0000);
        wr(8'h07, 8'h34);
        wr(8'h1f, 8'h0b);
        go(OP_JUMP, 13'h02f0);
        go(OP_SEQ);
        // Requests stay low around every table read
        for (int m = 0; m < 3; m++) begin
            pg = (m == 0) ? 5'h02 : (m == 1) ? 5'h0b : 5'h17;
            pc = o_rom_addr;
            @(posedge i_clk);
            i_table_pointer_high_en <= (m == 1);
            go(m == 2 ? OP_TBL_LAST : OP_TBL_CUR);
            chk("table addr", 16'(o_rom_addr), 16'({pg, 8'h34}));
            go(OP_SEQ);
            chk("table done", 16'(o_ir_dummy), 16'h0000);
            chk("table ret", 16'(o_rom_addr), 16'(pc + 13'h0001));
            rd(8'h08, {3'h5, pg}, "table high");
            rd(8'h50, 8'h34, "table low");
        end
        report_and_stop();
    end
endmodule : program_sequencer_stack_table_read_bench
